// *** hw/drive_mon_pkg.sv ***
// constants shared by the drive status output monitor
`default_nettype none
package drive_mon_pkg;
  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_HZ       = 50_000_000;  // REF_CLK_I rate
  localparam int unsigned TICK_TIME_MS = 1;           // delay step, ms
  localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_TIME_MS;
  localparam int unsigned DELAY_MAX_MS = 240_000;     // 240.000 s
  localparam int unsigned DELAY_W      = 18;          // holds 240000
  // ==========================================================
  // scaling: rpm for speeds, 0.01 % units for percentages
  localparam int unsigned PCT_FULL     = 10000;       // 100.00 %
  localparam int unsigned N_MAX_RPM    = 3000;        // nmax default
  localparam logic signed [17:0] HYS_RPM      = 18'sh00019; // 25 rpm
  localparam logic signed [17:0] TORQUE_WIN   = 18'sh02706; // 99.90 %
  localparam logic signed [17:0] TORQUE_HYS   = 18'sh000BE; // 1.90 %
  localparam logic signed [17:0] RAMP_HYS     = 18'sh00064; // 1 % nmax
  localparam logic signed [17:0] CORR_HYS     = 18'sh00032; // 0.50 %
  localparam int unsigned OVSP_HYS_PCT = 2;           // 2 % of nmax
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] SPEED_THR_OFS = 8'h00;
  localparam logic [7:0] STILL_THR_OFS = 8'h04;
  localparam logic [7:0] SETP_WIN_OFS  = 8'h08;
  localparam logic [7:0] RAMP_WIN_OFS  = 8'h0C;
  localparam logic [7:0] OVSP_THR_OFS  = 8'h10;
  localparam logic [7:0] CORR_THR_OFS  = 8'h14;
  localparam logic [7:0] CMP_STAT_OFS  = 8'h18;
  localparam logic [7:0] OUT_STAT_OFS  = 8'h1C;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h20;
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h24;
  localparam logic [7:0] OUT_CFG_OFS   = 8'h40;  // 13 words, one per out
  // output config word fields
  localparam int unsigned CFG_FUNC_LSB  = 0;     // [4:0] function code
  localparam int unsigned CFG_POL_BIT   = 7;     // polarity
  localparam int unsigned CFG_DELAY_LSB = 8;     // [25:8] delay in ms
  // ==========================================================
  // reset values of the settings
  localparam logic [15:0] SPEED_THR_RST = 16'hF448;  // -3000 rpm
  localparam logic [15:0] STILL_THR_RST = 16'h0032;  // 50 rpm
  localparam logic [15:0] SETP_WIN_RST  = 16'h0064;  // 1.00 %
  localparam logic [15:0] RAMP_WIN_RST  = 16'h0064;  // 1.00 %
  localparam logic [15:0] OVSP_THR_RST  = 16'h03E8;  // 1000 rpm
  localparam logic [15:0] CORR_THR_RST  = 16'h0064;  // 1.00 %
  // ==========================================================
  // function codes routed to outputs
  typedef enum logic [4:0] {
    FN_NONE     = 5'h00,
    FN_SPEED    = 5'h01,
    FN_TORQUE   = 5'h03,
    FN_TRIP     = 5'h06,
    FN_RAMP     = 5'h09,
    FN_SETP     = 5'h0A,
    FN_STILL    = 5'h0B,
    FN_CORR     = 5'h0E,
    FN_OVSP     = 5'h11
  } func_t;
  localparam int unsigned N_OUT  = 13;  // outputs 1..12 and relay
  localparam int unsigned N_TERM = 5;   // outputs on terminals
  localparam int unsigned N_CMP  = 7;   // comparator count
endpackage : drive_mon_pkg
`default_nettype wire

// *** hw/hyst_cmp.sv ***
// comparator with a switch-on level and a hysteresis switch-off level
`default_nettype none
module hyst_cmp #(
  parameter bit BELOW = 1'b0  // 1: active while value is at or below level
) (
  input  wire logic               REF_CLK_I,
  input  wire logic               NRST_I,
  input  wire logic signed [17:0] val_i,   // quantity watched
  input  wire logic signed [17:0] lvl_i,   // switch-on level
  input  wire logic signed [17:0] hys_i,   // hysteresis width
  output logic                    act_o    // function state
);
  // ==========================================================
  // switch-on when level is crossed, switch-off only past the offset
  logic signed [17:0] off_lvl;  // switch-off value
  assign off_lvl = BELOW ? 18'(lvl_i + hys_i) : 18'(lvl_i - hys_i);
  // state update
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      act_o <= 1'b0;
    end else if (BELOW) begin
      if (val_i <= lvl_i) act_o <= 1'b1;        // inside window
      else if (val_i > off_lvl) act_o <= 1'b0;  // left hysteresis band
    end else begin
      if (val_i >= lvl_i) act_o <= 1'b1;        // above threshold
      else if (val_i < off_lvl) act_o <= 1'b0;  // dropped below band
    end
  end
endmodule : hyst_cmp
`default_nettype wire

// *** hw/out_delay.sv ***
// stability delay for one output, counted in millisecond ticks
`default_nettype none
module out_delay #(
  parameter int unsigned DW = 18  // delay counter width
) (
  input  wire logic          REF_CLK_I,
  input  wire logic          NRST_I,
  input  wire logic          tick_i,   // one-cycle ms pulse
  input  wire logic [DW-1:0] dly_i,    // delay in ms, 0 = none
  input  wire logic          in_i,     // undelayed function
  output logic               out_o     // delayed function
);
  // ==========================================================
  logic [DW-1:0] cnt_reg;  // ticks seen with input stable and different
  // follow the input once it has been stable for the full delay
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cnt_reg <= '0;
      out_o   <= 1'b0;
    end else if (in_i == out_o) begin
      cnt_reg <= '0;                        // nothing pending
    end else if (dly_i == '0) begin
      out_o   <= in_i;                      // no delay programmed
      cnt_reg <= '0;
    end else if (tick_i) begin
      if (cnt_reg + 1'b1 >= dly_i) begin
        out_o   <= in_i;                    // stable long enough
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end
endmodule : out_delay
`default_nettype wire

// *** hw/drive_status_output_monitor.sv ***
// speed drive monitor: comparators, output routing, delays, AHB registers
//
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`default_nettype none
module drive_status_output_monitor #(
  parameter int unsigned TICK_DIV = drive_mon_pkg::TICK_CYCLES,
  parameter int unsigned NMAX     = drive_mon_pkg::N_MAX_RPM
) (
  input  wire logic               REF_CLK_I,
  input  wire logic               NRST_I,
  // AHB-Lite slave
  input  wire logic               HSEL_I,
  input  wire logic [31:0]        HADDR_I,
  input  wire logic [1:0]         HTRANS_I,
  input  wire logic               HWRITE_I,
  input  wire logic [2:0]         HSIZE_I,
  input  wire logic [31:0]        HWDATA_I,
  input  wire logic               HREADY_I,
  output logic [31:0]             HRDATA_O,
  output logic                    HREADYOUT_O,
  output logic                    HRESP_O,
  // speed loop quantities, same clock
  input  wire logic signed [15:0] SPEED_ACT_I,    // rpm
  input  wire logic signed [15:0] SPEED_SET_I,    // rpm
  input  wire logic signed [15:0] REG_OUT_I,      // 0.01 % of max
  input  wire logic signed [15:0] RAMP_IN_I,      // 0.01 % of nmax
  input  wire logic signed [15:0] RAMP_OUT_I,     // 0.01 % of nmax
  input  wire logic signed [15:0] FREQ_CORR_I,    // 0.01 %
  input  wire logic signed [15:0] ANA_CORR_I,     // 0.01 %
  input  wire logic [31:0]        DRIVE_FLAGS_I,  // other functions
  // outputs
  output logic [4:0]              TERM_OUT_O,     // outputs 1..5
  output logic                    RELAY_O,
  output logic [6:0]              SERIAL_OUT_O,   // outputs 6..12
  output logic                    IRQ_O
);
  // ==========================================================
  // settings registers
  logic [15:0] speed_thr_reg;   // speed_threshold_setting
  logic [15:0] still_thr_reg;   // standstill_threshold_setting
  logic [15:0] setp_win_reg;    // setpoint_match_window
  logic [15:0] ramp_win_reg;    // ramp_settled_window
  logic [15:0] ovsp_thr_reg;    // overspeed_threshold_setting
  logic [15:0] corr_thr_reg;    // correction_threshold_setting
  logic [4:0]  func_reg  [drive_mon_pkg::N_OUT];  // output_function_select
  logic        pol_reg   [drive_mon_pkg::N_OUT];  // output_polarity
  logic [drive_mon_pkg::DELAY_W-1:0] dly_reg [drive_mon_pkg::N_OUT];
  logic [6:0]  irq_stat_reg;    // sticky comparator rise events
  logic [6:0]  irq_mask_reg;    // interrupt enables
  // ==========================================================
  // bus state
  logic        wr_pend_reg;     // write data phase pending
  logic [7:0]  wr_addr_reg;     // byte address of pending write
  logic        addr_ok;         // valid address phase this cycle
  logic [31:0] rd_data;         // read mux
  logic [12:0] out_state;       // final output levels
  logic [6:0]  cmp;             // comparator results
  logic [6:0]  cmp_q_reg;       // previous comparator results
  logic [31:0] wdat;            // write data alias
  assign addr_ok = HSEL_I && HREADY_I && HTRANS_I[1];
  assign wdat    = HWDATA_I;
  // ==========================================================
  // millisecond tick divider
  logic [31:0] div_reg;   // cycle counter
  logic        tick_reg;  // one-cycle ms pulse
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else if (div_reg >= 32'(TICK_DIV - 1)) begin
      div_reg  <= '0;
      tick_reg <= 1'b1;   // ms step for delay counters
    end else begin
      div_reg  <= div_reg + 32'h0000_0001;
      tick_reg <= 1'b0;
    end
  end
  // ==========================================================
  // comparator inputs, widened to 18 bits signed
  logic signed [17:0] n_act, n_abs, reg_abs, ramp_abs, setp_abs;
  logic signed [17:0] fc_abs, ac_abs, corr_max, setp_win_rpm, ovsp_hys;
  logic [31:0]        setp_prod;  // window scaled to rpm
  always_comb begin
    n_act    = 18'(SPEED_ACT_I);
    n_abs    = (n_act < 0) ? -n_act : n_act;
    reg_abs  = (REG_OUT_I < 0) ? -18'(REG_OUT_I) : 18'(REG_OUT_I);
    ramp_abs = 18'(RAMP_IN_I) - 18'(RAMP_OUT_I);
    ramp_abs = (ramp_abs < 0) ? -ramp_abs : ramp_abs;
    setp_abs = n_act - 18'(SPEED_SET_I);
    setp_abs = (setp_abs < 0) ? -setp_abs : setp_abs;
    fc_abs   = (FREQ_CORR_I < 0) ? -18'(FREQ_CORR_I) : 18'(FREQ_CORR_I);
    ac_abs   = (ANA_CORR_I < 0) ? -18'(ANA_CORR_I) : 18'(ANA_CORR_I);
    corr_max = (fc_abs > ac_abs) ? fc_abs : ac_abs;
    setp_prod = 32'(setp_win_reg) * 32'(NMAX) / 32'(drive_mon_pkg::PCT_FULL);
    setp_win_rpm = 18'(setp_prod);
    ovsp_hys = 18'(NMAX * drive_mon_pkg::OVSP_HYS_PCT / 100);
  end
  // ==========================================================
  // hysteresis comparators, switch-off offset by hysteresis
  hyst_cmp #(.BELOW(1'b0)) u_speed (
    .REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I), .val_i(n_act),
    .lvl_i(18'($signed(speed_thr_reg))), .hys_i(drive_mon_pkg::HYS_RPM),
    .act_o(cmp[0]));
  hyst_cmp #(.BELOW(1'b0)) u_torque (
    .REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I), .val_i(reg_abs),
    .lvl_i(drive_mon_pkg::TORQUE_WIN), .hys_i(drive_mon_pkg::TORQUE_HYS),
    .act_o(cmp[1]));
  hyst_cmp #(.BELOW(1'b1)) u_ramp (
    .REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I), .val_i(ramp_abs),
    .lvl_i(18'(ramp_win_reg)), .hys_i(drive_mon_pkg::RAMP_HYS),
    .act_o(cmp[2]));
  hyst_cmp #(.BELOW(1'b1)) u_still (
    .REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I), .val_i(n_abs),
    .lvl_i(18'(still_thr_reg)), .hys_i(drive_mon_pkg::HYS_RPM),
    .act_o(cmp[3]));
  hyst_cmp #(.BELOW(1'b1)) u_setp (
    .REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I), .val_i(setp_abs),
    .lvl_i(setp_win_rpm), .hys_i(drive_mon_pkg::HYS_RPM),
    .act_o(cmp[4]));
  hyst_cmp #(.BELOW(1'b0)) u_ovsp (
    .REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I), .val_i(n_abs),
    .lvl_i(18'(ovsp_thr_reg)), .hys_i(ovsp_hys),
    .act_o(cmp[5]));
  hyst_cmp #(.BELOW(1'b0)) u_corr (
    .REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I), .val_i(corr_max),
    .lvl_i(18'(corr_thr_reg)), .hys_i(drive_mon_pkg::CORR_HYS),
    .act_o(cmp[6]));
  // ==========================================================
  // function select: own comparators or an external drive flag
  function automatic logic fsel(input logic [4:0] f, input logic [6:0] c,
                                input logic [31:0] fl);
    case (f)
      drive_mon_pkg::FN_NONE:   fsel = 1'b0;
      drive_mon_pkg::FN_SPEED:  fsel = c[0];
      drive_mon_pkg::FN_TORQUE: fsel = c[1];
      drive_mon_pkg::FN_RAMP:   fsel = c[2];
      drive_mon_pkg::FN_STILL:  fsel = c[3];
      drive_mon_pkg::FN_SETP:   fsel = c[4];
      drive_mon_pkg::FN_OVSP:   fsel = c[5];
      drive_mon_pkg::FN_CORR:   fsel = c[6];
      default:                  fsel = fl[f];
    endcase
  endfunction : fsel
  // per output: select, delay (terminals and relay), polarity
  logic [12:0] fn_raw;   // selected function
  logic [12:0] fn_dly;   // after delay
  genvar gi;
  generate
    for (gi = 0; gi < drive_mon_pkg::N_OUT; gi++) begin : g_out
      assign fn_raw[gi] = fsel(func_reg[gi], cmp, DRIVE_FLAGS_I);
      if (gi < drive_mon_pkg::N_TERM || gi == drive_mon_pkg::N_OUT - 1)
      begin : g_dly
        out_delay #(.DW(drive_mon_pkg::DELAY_W)) u_dly (
          .REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I), .tick_i(tick_reg),
          .dly_i(dly_reg[gi]), .in_i(fn_raw[gi]), .out_o(fn_dly[gi]));
      end else begin : g_nodly
        assign fn_dly[gi] = fn_raw[gi];
      end
      assign out_state[gi] = fn_dly[gi] ^ pol_reg[gi];
    end
  endgenerate
  // registered pins: 1..5 terminals, 6..12 serial, relay
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      TERM_OUT_O   <= '0;
      SERIAL_OUT_O <= '0;
      RELAY_O      <= 1'b0;
    end else begin
      TERM_OUT_O   <= out_state[4:0];
      SERIAL_OUT_O <= out_state[11:5];
      RELAY_O      <= out_state[12];
    end
  end
  // ==========================================================
  // AHB write: address phase latched, data applied in data phase
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else begin
      wr_pend_reg <= addr_ok && HWRITE_I;
      wr_addr_reg <= HADDR_I[7:0];
    end
  end
  // settings registers with defaults
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      speed_thr_reg <= drive_mon_pkg::SPEED_THR_RST;
      still_thr_reg <= drive_mon_pkg::STILL_THR_RST;
      setp_win_reg  <= drive_mon_pkg::SETP_WIN_RST;
      ramp_win_reg  <= drive_mon_pkg::RAMP_WIN_RST;
      ovsp_thr_reg  <= drive_mon_pkg::OVSP_THR_RST;
      corr_thr_reg  <= drive_mon_pkg::CORR_THR_RST;
      irq_mask_reg  <= '0;
    end else if (wr_pend_reg) begin
      case (wr_addr_reg)
        drive_mon_pkg::SPEED_THR_OFS: speed_thr_reg <= wdat[15:0];
        drive_mon_pkg::STILL_THR_OFS: still_thr_reg <= wdat[15:0];
        drive_mon_pkg::SETP_WIN_OFS:  setp_win_reg  <= wdat[15:0];
        drive_mon_pkg::RAMP_WIN_OFS:  ramp_win_reg  <= wdat[15:0];
        drive_mon_pkg::OVSP_THR_OFS:  ovsp_thr_reg  <= wdat[15:0];
        drive_mon_pkg::CORR_THR_OFS:  corr_thr_reg  <= wdat[15:0];
        drive_mon_pkg::IRQ_MASK_OFS:  irq_mask_reg  <= wdat[6:0];
        default: ;   // other offsets ignored
      endcase
    end
  end
  // per-output configuration words, defaults as factory routing
  localparam logic [4:0] FUNC_RST [13] = '{5'h01, 5'h03, 5'h09, 5'h0B,
    5'h0A, 5'h07, 5'h08, 5'h0C, 5'h0D, 5'h02, 5'h04, 5'h05, 5'h06};
  localparam logic [12:0] POL_RST = 13'h1009;  // outputs 1, 4, relay low
  generate
    for (gi = 0; gi < drive_mon_pkg::N_OUT; gi++) begin : g_cfg
      always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
          func_reg[gi] <= FUNC_RST[gi];
          pol_reg[gi]  <= POL_RST[gi];
          dly_reg[gi]  <= '0;   // zero delay after reset
        end else if (wr_pend_reg &&
                     wr_addr_reg == 8'(drive_mon_pkg::OUT_CFG_OFS + 4*gi))
        begin
          func_reg[gi] <= wdat[4:0];
          pol_reg[gi]  <= wdat[drive_mon_pkg::CFG_POL_BIT];
          dly_reg[gi]  <= (wdat[25:8] > 18'(drive_mon_pkg::DELAY_MAX_MS)) ?
                          18'(drive_mon_pkg::DELAY_MAX_MS) : wdat[25:8];
        end
      end
    end
  endgenerate
  // ==========================================================
  // interrupt status: rise of a comparator, write one to clear
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cmp_q_reg    <= '0;
      irq_stat_reg <= '0;
      IRQ_O        <= 1'b0;
    end else begin
      cmp_q_reg <= cmp;
      // set wins over a clear in the same cycle
      if (wr_pend_reg && wr_addr_reg == drive_mon_pkg::IRQ_STAT_OFS)
        irq_stat_reg <= (irq_stat_reg & ~wdat[6:0]) | (cmp & ~cmp_q_reg);
      else
        irq_stat_reg <= irq_stat_reg | (cmp & ~cmp_q_reg);
      IRQ_O <= |(irq_stat_reg & irq_mask_reg);
    end
  end
  // ==========================================================
  // read mux and answer
  always_comb begin
    rd_data = '0;
    case (HADDR_I[7:0])
      drive_mon_pkg::SPEED_THR_OFS: rd_data = {16'h0000, speed_thr_reg};
      drive_mon_pkg::STILL_THR_OFS: rd_data = {16'h0000, still_thr_reg};
      drive_mon_pkg::SETP_WIN_OFS:  rd_data = {16'h0000, setp_win_reg};
      drive_mon_pkg::RAMP_WIN_OFS:  rd_data = {16'h0000, ramp_win_reg};
      drive_mon_pkg::OVSP_THR_OFS:  rd_data = {16'h0000, ovsp_thr_reg};
      drive_mon_pkg::CORR_THR_OFS:  rd_data = {16'h0000, corr_thr_reg};
      drive_mon_pkg::CMP_STAT_OFS:  rd_data = {25'h0, cmp};
      drive_mon_pkg::OUT_STAT_OFS:  rd_data = {19'h0, out_state};
      drive_mon_pkg::IRQ_STAT_OFS:  rd_data = {25'h0, irq_stat_reg};
      drive_mon_pkg::IRQ_MASK_OFS:  rd_data = {25'h0, irq_mask_reg};
      default: begin
        for (int k = 0; k < drive_mon_pkg::N_OUT; k++) begin
          if (HADDR_I[7:0] == 8'(drive_mon_pkg::OUT_CFG_OFS + 4*k))
            rd_data = {6'h00, dly_reg[k], pol_reg[k], 2'h0, func_reg[k]};
        end
      end
    endcase
  end
  // zero-wait slave, always OKAY, read data held from address phase
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      HRDATA_O    <= '0;
      HREADYOUT_O <= 1'b0;
      HRESP_O     <= 1'b0;
    end else begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
      if (addr_ok && !HWRITE_I) HRDATA_O <= rd_data;
    end
  end
  // ==========================================================
  // checks
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!NRST_I);
  a_speed_on: assert property (
    n_act >= 18'($signed(speed_thr_reg)) |=> cmp[0])
    else $error("speed threshold not activated");
  a_torque_on: assert property (
    reg_abs >= 18'sd9990 |=> cmp[1])
    else $error("torque limit not activated");
  a_ramp_off: assert property (
    ramp_abs > 18'(ramp_win_reg) + 18'sd100 |=> !cmp[2])
    else $error("ramp settled not released");
  a_still_off: assert property (
    n_abs > 18'(still_thr_reg) + 18'sd25 |=> !cmp[3])
    else $error("standstill not released");
  a_setp_on: assert property (
    setp_abs <= setp_win_rpm |=> cmp[4])
    else $error("setpoint match not activated");
  a_ovsp_off: assert property (
    n_abs < $signed(18'(ovsp_thr_reg)) - ovsp_hys |=> !cmp[5])
    else $error("overspeed not released");
  a_corr_on: assert property (
    corr_max >= 18'(corr_thr_reg) |=> cmp[6])
    else $error("correction not activated");
  a_corr_off: assert property (
    corr_max < $signed(18'(corr_thr_reg)) - drive_mon_pkg::CORR_HYS
    |=> !cmp[6])
    else $error("correction not released");
  a_speed_off: assert property (
    n_act < 18'($signed(speed_thr_reg)) - drive_mon_pkg::HYS_RPM
    |=> !cmp[0])
    else $error("speed threshold not released");
  a_torque_hold: assert property (
    cmp[1] && reg_abs >= 18'sd9800 |=> cmp[1])
    else $error("torque limit dropped inside band");
  a_pol_idle: assert property (
    func_reg[5] == 5'h00 [*2] |=> SERIAL_OUT_O[0] == $past(pol_reg[5]))
    else $error("idle output ignores polarity");
  a_delay_tick: assert property (
    $changed(fn_dly[1]) && $past(dly_reg[1]) != '0 |-> $past(tick_reg))
    else $error("delayed output moved without tick");
  a_irq_level: assert property (
    |(irq_stat_reg & irq_mask_reg) |=> IRQ_O)
    else $error("interrupt not raised");
  c_torque_rise: cover property (!cmp[1] ##1 cmp[1]);
  c_delay_done: cover property (fn_raw[1] != fn_dly[1] ##[1:300]
    $changed(fn_dly[1]));
  c_still_rise: cover property (!cmp[3] ##1 cmp[3]);
  c_irq_clear: cover property (IRQ_O ##[1:20] !IRQ_O);
endmodule : drive_status_output_monitor
`default_nettype wire

// *** bench/speed_loop_model.sv ***
// speed loop model: puts requested quantities on the monitor inputs
`default_nettype none
module speed_loop_model (
  input  wire logic               clk_i,
  input  wire logic               nrst_i,
  input  wire logic signed [15:0] act_i,   // requested actual speed
  input  wire logic signed [15:0] set_i,   // requested setpoint speed
  output logic signed [15:0]      act_o,   // actual speed, rpm
  output logic signed [15:0]      set_o,   // setpoint speed, rpm
  output logic signed [15:0]      rin_o,   // ramp input, 0.01 %
  output logic signed [15:0]      rout_o   // ramp output, 0.01 %
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // loop values change only at the clock edge, as a sampled loop does
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      act_o  <= 16'sh0000;
      set_o  <= 16'sh0000;
      rin_o  <= 16'sh0000;
      rout_o <= 16'sh0000;
    end else begin
      act_o  <= act_i;
      set_o  <= set_i;
      rin_o  <= set_i;
      rout_o <= act_i;
    end
  end
endmodule : speed_loop_model
`default_nettype wire

// *** bench/tb.sv ***
// testbench: registers, comparators, routing, delay and interrupt
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk = 1'b0, nrst = 1'b0, hw = 1'b0;
  logic [1:0]         htr = 2'h0;
  logic [31:0]        ha = 32'h0, hwd = 32'h0, flg = 32'h0, rd, q;
  logic               hr, hrsp, irq, rly;
  logic [4:0]         term;
  logic [6:0]         ser;
  logic signed [15:0] a = 16'sh0, s = 16'sh0, tq = 16'sh0, fc = 16'sh0,
                      sa, ss, ri, ro;
  int                 n_mismatch = 0, cmp_count = 0, n;
  always #10 clk = ~clk;
  speed_loop_model lm_u (.clk_i(clk), .nrst_i(nrst), .act_i(a),
    .set_i(s), .act_o(sa), .set_o(ss), .rin_o(ri), .rout_o(ro));
  drive_status_output_monitor #(.TICK_DIV(10)) dut_u (.REF_CLK_I(clk),
    .NRST_I(nrst), .HSEL_I(1'b1), .HADDR_I(ha), .HTRANS_I(htr),
    .HWRITE_I(hw), .HSIZE_I(3'h2), .HWDATA_I(hwd), .HREADY_I(hr),
    .HRDATA_O(rd), .HREADYOUT_O(hr), .HRESP_O(hrsp), .SPEED_ACT_I(sa),
    .SPEED_SET_I(ss), .REG_OUT_I(tq), .RAMP_IN_I(ri),
    .RAMP_OUT_I(ro), .FREQ_CORR_I(fc), .ANA_CORR_I(16'sh0),
    .DRIVE_FLAGS_I(flg), .TERM_OUT_O(term), .RELAY_O(rly),
    .SERIAL_OUT_O(ser), .IRQ_O(irq));
  // ==========================================================
  // verdict and shared compare
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  // ==========================================================
  // one ahb single transfer; ready is awaited with a bound
  task automatic wrdy;
    int k;
    k = 0;
    do begin @(posedge clk); k++; end while (hr !== 1'b1 && k < 50);
    if (hr !== 1'b1) begin n_mismatch++; test_done(); end
  endtask : wrdy
  task automatic bus(input logic [7:0] ad, input logic w,
                     input logic [31:0] d);
    htr <= 2'h2; ha <= {24'h0, ad}; hw <= w;
    wrdy();
    htr <= 2'h0; hwd <= d;
    wrdy();
    q = rd;
  endtask : bus
  task automatic rdc(input logic [7:0] ad, input logic [31:0] m, e);
    bus(ad, 1'b0, 32'h0);
    chk(q & m, e);
  endtask : rdc
  // ==========================================================
  // test sequence
  int         sv[6] = '{100, 76, 74, 0, 75, 76};
  logic [3:0] ev[6] = '{4'h1, 4'h1, 4'h0, 4'h8, 4'h8, 4'h0};
  logic [7:0] ro_ofs[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [15:0] rv[6] = '{16'hF448, 16'h0032, 16'h0064, 16'h0064,
                         16'h03E8, 16'h0064};
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    // default settings of every threshold and window
    for (int i = 0; i < 6; i++) rdc(ro_ofs[i], 32'hFFFF, rv[i]);
    rdc(drive_mon_pkg::OUT_CFG_OFS, 32'h03FFFFFF, 32'h81);
    rdc(8'h30, 32'hFFFFFFFF, 32'h0);
    bus(drive_mon_pkg::SPEED_THR_OFS, 1'b1, 32'h64);
    // speed and standstill switch-on and switch-off points
    for (int i = 0; i < 6; i++) begin
      a <= 16'(sv[i]);
      repeat (4) @(posedge clk);
      rdc(drive_mon_pkg::CMP_STAT_OFS, 32'h9, 32'(ev[i]));
      chk({term[3], term[0]}, {~ev[i][3], ~ev[i][0]});
    end
    // events latch, mask drives the interrupt, write one clears
    rdc(drive_mon_pkg::IRQ_STAT_OFS, 32'h9, 32'h9);
    bus(drive_mon_pkg::IRQ_MASK_OFS, 1'b1, 32'h8);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    bus(drive_mon_pkg::IRQ_STAT_OFS, 1'b1, 32'h7F);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    // output 2 on speed, high true, three ms delay
    bus(drive_mon_pkg::OUT_CFG_OFS + 8'h4, 1'b1, 32'h301);
    repeat (5) @(posedge clk);
    chk(term[1], 1'b0);
    a <= 16'sd100;
    n = 0;
    while (term[1] !== 1'b1 && n < 100) begin @(posedge clk); n++; end
    chk(n >= 20 && n <= 45, 1'b1);
    // serial only output follows its function, terminals untouched
    flg <= 32'h80;
    repeat (4) @(posedge clk);
    chk(ser[0], 1'b1);
    // speed on, delayed speed on, ramp settled, no standstill, no match
    chk(term, 5'h0E);
    // output 6 with no function shows its polarity alone
    bus(drive_mon_pkg::OUT_CFG_OFS + 8'h14, 1'b1, 32'h80);
    repeat (4) @(posedge clk);
    chk(ser[0], 1'b1);
    // torque limit and correction magnitude, held inside the band
    tq <= 16'sd9990;
    fc <= -16'sd100;
    repeat (3) @(posedge clk);
    rdc(drive_mon_pkg::CMP_STAT_OFS, 32'h42, 32'h42);
    tq <= 16'sd9800;
    fc <= 16'sd50;
    repeat (3) @(posedge clk);
    rdc(drive_mon_pkg::CMP_STAT_OFS, 32'h42, 32'h42);
    tq <= -16'sd9799;
    fc <= 16'sd49;
    repeat (3) @(posedge clk);
    rdc(drive_mon_pkg::CMP_STAT_OFS, 32'h42, 32'h0);
    test_done();
  end
endmodule : tb
`default_nettype wire
